// ### hdl/latched_piso_shift_register.sv
// Storage latch feeding a parallel-in serial-out shift register
`timescale 1ns/10ps
module latched_piso_shift_register
    import piso_pkg::*;
#(
    parameter bit BIDIRECTIONAL = 1'b1
)
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic storageClock,
    input wire logic shiftClock,
    input wire logic shiftClockGate,
    input wire logic loadFromLatch_n,
    input wire logic shiftClear_n,
    input wire logic serialInputA,
    input wire logic serialInputB,
    input wire logic serialSourceSelect,
    input wire logic parallelDriveEnable_n,
    input wire logic [DATA_WIDTH-1:0] parallelPinIn,
    output logic [DATA_WIDTH-1:0] parallelPinOut,
    output logic parallelPinOe_n,
    output logic serialOut
);
    // Elaboration check on the width
    if (DATA_WIDTH < 2) begin : gWidthCheck
        $error("Shift register needs at least two stages");
    end

    pisoState_t stateQ;
    pisoState_t stateD;
    logic storageRise;
    logic shiftRise;
    logic shiftStep;
    logic serialIn;
    logic [DATA_WIDTH-1:0] shiftNext;

    // Shift edges count only while clear and load are both idle
    function automatic logic shiftIdle(input logic clearLevel_n, input logic loadLevel_n);
        return clearLevel_n & loadLevel_n;
    endfunction

    // Clock edge detection, one per register
    rise_detect uStorageEdge (
        .clk(clk),
        .reset_n(reset_n),
        .level(storageClock),
        .rise(storageRise)
    );

    rise_detect uShiftEdge (
        .clk(clk),
        .reset_n(reset_n),
        .level(shiftClock),
        .rise(shiftRise)
    );

    // Serial source choice
    always_comb begin
        if (BIDIRECTIONAL && serialSourceSelect) begin
            serialIn = serialInputB;
        end else begin
            serialIn = serialInputA;
        end
    end

    // Shift clock qualified by its gate
    assign shiftStep = shiftRise & ~shiftClockGate;

    // Next value of each stage for a taken shift edge
    for (genvar stage = FIRST_STAGE; stage <= LAST_STAGE; stage++) begin : gStage
        if (stage == FIRST_STAGE) begin : gEntry
            assign shiftNext[stage] = serialIn;
        end else begin : gMove
            assign shiftNext[stage] = stateQ.shift[stage-1];
        end
    end

    always_comb begin
        stateD = stateQ;
        if (storageRise) begin
            // Pins carry the resolved wire, which is the input when not driven
            stateD.storage = parallelPinIn;
        end
        if (!shiftClear_n) begin
            stateD.shift = SHIFT_CLEARED;
        end else if (!loadFromLatch_n) begin
            stateD.shift = stateQ.storage;
        end else if (shiftStep) begin
            stateD.shift = shiftNext;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            stateQ.storage <= STORAGE_RESET;
            stateQ.shift <= SHIFT_RESET;
        end else begin
            stateQ <= stateD;
        end
    end

    // Outputs
    assign serialOut = stateQ.shift[LAST_STAGE];
    assign parallelPinOut = stateQ.shift;
    assign parallelPinOe_n = BIDIRECTIONAL ? parallelDriveEnable_n : 1'b1;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    a_clear_zeros: assert property (
        !shiftClear_n |=> stateQ.shift == SHIFT_CLEARED
    ) else $error("Shift register not zero after clear");

    a_clear_serial: assert property (
        !shiftClear_n [*2] |-> !serialOut
    ) else $error("Serial output high during clear");

    a_load_storage: assert property (
        shiftClear_n && !loadFromLatch_n |=> parallelPinOut == $past(stateQ.storage)
    ) else $error("Load did not copy storage");

    a_storage_capture: assert property (
        storageRise |=> stateQ.storage == $past(parallelPinIn)
    ) else $error("Storage missed parallel inputs");

    a_storage_hold: assert property (
        !storageRise |=> $stable(stateQ.storage)
    ) else $error("Storage changed without its clock");

    a_shift_hold: assert property (
        shiftClear_n && loadFromLatch_n && !shiftStep |=> $stable(parallelPinOut)
    ) else $error("Shift register changed without its clock");

    a_shift_move: assert property (
        shiftClear_n && loadFromLatch_n && shiftStep
            |=> parallelPinOut[LAST_STAGE:1] == $past(parallelPinOut[LAST_STAGE-1:0])
    ) else $error("Shift did not move one stage");

    a_serial_entry: assert property (
        shiftClear_n && loadFromLatch_n && shiftStep |=> parallelPinOut[FIRST_STAGE] == $past(serialIn)
    ) else $error("Wrong serial bit entered");

    a_gate_blocks: assert property (
        shiftClear_n && loadFromLatch_n && shiftRise && shiftClockGate |=> $stable(parallelPinOut)
    ) else $error("Gated shift edge moved data");

    a_drive_enable: assert property (
        parallelPinOe_n == (BIDIRECTIONAL ? parallelDriveEnable_n : 1'b1)
    ) else $error("Pin enable does not follow drive enable");

    a_last_stage: assert property (
        serialOut == parallelPinOut[LAST_STAGE]
    ) else $error("Serial output is not last stage");

    a_edge_storage: assert property (
        storageRise |-> storageClock && !$past(storageClock)
    ) else $error("Storage edge without a low to high step");

    a_edge_shift: assert property (
        shiftRise |-> shiftClock && !$past(shiftClock)
    ) else $error("Shift edge without a low to high step");

    a_storage_spacing: assert property (
        storageRise |=> !storageRise
    ) else $error("Storage edge seen twice in a row");

    a_shift_spacing: assert property (
        shiftRise |=> !shiftRise
    ) else $error("Shift edge seen twice in a row");

    a_source_a: assert property (
        shiftIdle(shiftClear_n, loadFromLatch_n) && shiftStep && !serialSourceSelect
            |=> parallelPinOut[FIRST_STAGE] == $past(serialInputA)
    ) else $error("Serial input a not taken");

    a_source_b: assert property (
        BIDIRECTIONAL && shiftIdle(shiftClear_n, loadFromLatch_n) && shiftStep && serialSourceSelect
            |=> parallelPinOut[FIRST_STAGE] == $past(serialInputB)
    ) else $error("Serial input b not taken");

    a_plain_source: assert property (
        !BIDIRECTIONAL && shiftIdle(shiftClear_n, loadFromLatch_n) && shiftStep
            |=> parallelPinOut[FIRST_STAGE] == $past(serialInputA)
    ) else $error("Latch only variant left serial input a");

    a_serial_follow: assert property (
        shiftIdle(shiftClear_n, loadFromLatch_n) && shiftStep
            |=> serialOut == $past(parallelPinOut[LAST_STAGE-1])
    ) else $error("Serial output did not take the stage before last");

    a_load_serial: assert property (
        shiftClear_n && !loadFromLatch_n
            |=> serialOut == $past(stateQ.storage[LAST_STAGE])
    ) else $error("Load did not reach serial output");

    a_load_over_shift: assert property (
        shiftClear_n && !loadFromLatch_n && shiftStep
            |=> parallelPinOut == $past(stateQ.storage)
    ) else $error("Shift edge beat load");

    a_clear_over_load: assert property (
        !shiftClear_n && !loadFromLatch_n
            |=> parallelPinOut == SHIFT_CLEARED && !serialOut
    ) else $error("Load beat clear");

    a_gate_serial: assert property (
        shiftIdle(shiftClear_n, loadFromLatch_n) && shiftRise && shiftClockGate
            |=> $stable(serialOut)
    ) else $error("Gated shift edge moved serial output");

    a_clear_storage: assert property (
        !shiftClear_n && !storageRise |=> $stable(stateQ.storage)
    ) else $error("Clear disturbed storage");

    a_plain_no_drive: assert property (
        !BIDIRECTIONAL |-> parallelPinOe_n
    ) else $error("Latch only variant drives pins");

    a_drive_follow: assert property (
        BIDIRECTIONAL |-> parallelPinOe_n == parallelDriveEnable_n
    ) else $error("Pin drive does not follow enable");
endmodule // latched_piso_shift_register

// ### hdl/piso_pkg.sv
// Package with widths, reset values and state carriers of the latched shift register
package piso_pkg;
    localparam int DATA_WIDTH = 8;
    localparam logic [DATA_WIDTH-1:0] STORAGE_RESET = 8'h00;
    localparam logic [DATA_WIDTH-1:0] SHIFT_RESET = 8'h00;
    localparam logic [DATA_WIDTH-1:0] SHIFT_CLEARED = 8'h00;
    localparam int FIRST_STAGE = 0;
    localparam int LAST_STAGE = DATA_WIDTH - 1;
    localparam logic EDGE_PREV_RESET = 1'b1;

    typedef struct packed {
        logic [DATA_WIDTH-1:0] storage;
        logic [DATA_WIDTH-1:0] shift;
    } pisoState_t;

    typedef struct packed {
        logic prev;
    } edgeState_t;
endpackage

// ### hdl/rise_detect.sv
// Rising edge detector for a level sampled on clk
`timescale 1ns/10ps
module rise_detect
    import piso_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic level,
    output logic rise
);
    edgeState_t stateQ;
    edgeState_t stateD;

    always_comb begin
        stateD = stateQ;
        stateD.prev = level;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            stateQ.prev <= EDGE_PREV_RESET;
        end else begin
            stateQ <= stateD;
        end
    end

    // Pulse in the cycle where the level is first seen high
    assign rise = level & ~stateQ.prev;
endmodule // rise_detect

// ### sim/latched_piso_shift_register_tb_top.sv
// Self-checking bench of the latched shift register
`timescale 1ns/10ps
module latched_piso_shift_register_tb_top;
    import piso_pkg::*;
    logic clk, reset_n, stClk, shClk, gate, load_n, clr_n, serA, serB, sel, drvEn_n, oe_n, sOut;
    logic [DATA_WIDTH-1:0] ext, pins, pOut, exp;
    logic oePlain_n, sOutPlain;
    logic [DATA_WIDTH-1:0] pOutPlain, expPlain;
    int fails, n_checks;
    latched_piso_shift_register dut (.clk(clk), .reset_n(reset_n), .storageClock(stClk),
        .shiftClock(shClk), .shiftClockGate(gate), .loadFromLatch_n(load_n), .shiftClear_n(clr_n),
        .serialInputA(serA), .serialInputB(serB), .serialSourceSelect(sel),
        .parallelDriveEnable_n(drvEn_n), .parallelPinIn(pins), .parallelPinOut(pOut),
        .parallelPinOe_n(oe_n), .serialOut(sOut));
    pin_driver_model far (.devOut(pOut), .devOe_n(oe_n), .extData(ext), .pinWire(pins));
    latched_piso_shift_register #(.BIDIRECTIONAL(1'b0)) dutPlain (.clk(clk), .reset_n(reset_n),
        .storageClock(stClk), .shiftClock(shClk), .shiftClockGate(gate), .loadFromLatch_n(load_n),
        .shiftClear_n(clr_n), .serialInputA(serA), .serialInputB(serB), .serialSourceSelect(sel),
        .parallelDriveEnable_n(drvEn_n), .parallelPinIn(ext), .parallelPinOut(pOutPlain),
        .parallelPinOe_n(oePlain_n), .serialOut(sOutPlain));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task step(input int n);
        repeat (n) @(negedge clk);
    endtask
    task check(input string name, input logic [7:0] seen, input logic [7:0] want);
        n_checks++;
        if (seen !== want) begin
            fails++;
            $display("ERROR %s expected %h seen %h", name, want, seen);
        end
    endtask
    task give_verdict;
        if (fails == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task load_storage;
        ext = 8'hA5;
        drvEn_n = 1'b1;
        stClk = 1'b1;
        step(1);
        stClk = 1'b0;
        step(2);
        check("oe", {7'h00, oe_n}, 8'h01);
        check("oePlain", {7'h00, oePlain_n}, 8'h01);
        load_n = 1'b0;
        step(2);
        exp = 8'hA5;
        check("pins", pOut, exp);
        check("ser", {7'h00, sOut}, 8'h01);
        check("pinsPlain", pOutPlain, exp);
        check("serPlain", {7'h00, sOutPlain}, 8'h01);
        load_n = 1'b1;
        step(1);
    endtask
    task shift_all;
        serA = 1'b1;
        serB = 1'b0;
        drvEn_n = 1'b0;
        expPlain = exp;
        for (int i = 0; i < 8; i++) begin
            sel = i[0];
            shClk = 1'b1;
            step(1);
            shClk = 1'b0;
            step(2);
            exp = {exp[DATA_WIDTH-2:0], ~sel};
            check("pins", pOut, exp);
            check("ser", {7'h00, sOut}, {7'h00, exp[LAST_STAGE]});
            expPlain = {expPlain[DATA_WIDTH-2:0], 1'b1};
            check("pinsPlain", pOutPlain, expPlain);
            check("serPlain", {7'h00, sOutPlain}, {7'h00, expPlain[LAST_STAGE]});
        end
        check("oe", {7'h00, oe_n}, 8'h00);
        check("oePlain", {7'h00, oePlain_n}, 8'h01);
        gate = 1'b1;
        shClk = 1'b1;
        step(1);
        shClk = 1'b0;
        step(2);
        check("gated", pOut, exp);
        check("gatedPlain", pOutPlain, expPlain);
        gate = 1'b0;
    endtask
    task clear_over_load;
        clr_n = 1'b0;
        load_n = 1'b0;
        step(2);
        check("clr", pOut, SHIFT_CLEARED);
        check("ser", {7'h00, sOut}, 8'h00);
        check("clrPlain", pOutPlain, SHIFT_CLEARED);
        check("serPlain", {7'h00, sOutPlain}, 8'h00);
        clr_n = 1'b1;
        step(2);
        check("load", pOut, 8'hA5);
        check("loadPlain", pOutPlain, 8'hA5);
        load_n = 1'b1;
    endtask
    task load_takes_old;
        clr_n = 1'b0;
        step(1);
        check("clrOnce", pOut, SHIFT_CLEARED);
        clr_n = 1'b1;
        drvEn_n = 1'b1;
        ext = 8'h3C;
        stClk = 1'b1;
        load_n = 1'b0;
        step(1);
        check("oldLoad", pOut, 8'hA5);
        check("oldLoadPlain", pOutPlain, 8'hA5);
        stClk = 1'b0;
        shClk = 1'b1;
        step(1);
        check("newLoad", pOut, 8'h3C);
        check("newLoadPlain", pOutPlain, 8'h3C);
        shClk = 1'b0;
        load_n = 1'b1;
        step(2);
        check("loadHeld", pOut, 8'h3C);
        check("loadHeldPlain", pOutPlain, 8'h3C);
    endtask
    initial begin
        {stClk, shClk, gate, serA, serB, sel} = 6'h00;
        {load_n, clr_n, drvEn_n} = 3'h7;
        ext = 8'h00;
        reset_n = 1'b0;
        step(16);
        reset_n = 1'b1;
        step(1);
        check("reset", pOut, SHIFT_RESET);
        check("resetPlain", pOutPlain, SHIFT_RESET);
        load_storage();
        shift_all();
        clear_over_load();
        load_takes_old();
        give_verdict();
    end
    initial begin
        #80000;
        fails++;
        give_verdict();
    end
endmodule // latched_piso_shift_register_tb_top

// ### sim/pin_driver_model.sv
// Far-side logic sharing the parallel pins with the device
`timescale 1ns/10ps
module pin_driver_model
    import piso_pkg::*;
(
    input wire logic [DATA_WIDTH-1:0] devOut,
    input wire logic devOe_n,
    input wire logic [DATA_WIDTH-1:0] extData,
    output logic [DATA_WIDTH-1:0] pinWire
);
    assign pinWire = devOe_n ? extData : devOut;
endmodule // pin_driver_model
